// *** src/cssr_top.sv ***
// APB slave holding sequence stack entries fourteen to sixteen and the
// sequencer that walks them and drives the two converters' channel selects.
// Assumes conv_start and conv_done are single-cycle pulses on clk.
//
// Operation
// - Bit 15: zero read, one write.
// - Bits 14:9 hold the entry's own address.
// - Direction one updates the addressed entry fields.
// - Return flag zero: advance to next entry, or back to first after the last entry.
// - Return flag one: go back to first.
// - Bits 7:4 pick converter B channel.
// - Bits 3:0 pick converter A channel.
// - Entry fifteen at 0x2F, reset 0x5E00.
// - Entry sixteen at 0x30, reset 0x6000.
`timescale 1ns/1ps
`default_nettype none
`include "cssr_params.svh"

module cssr_top #(
  parameter int NUM_ENTRIES = 3
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter timing.
  input wire logic seq_enable,
  input wire logic conv_start,
  input wire logic conv_done,
  // Converter channel selects.
  output cssr_pkg::cssr_chan_t converter_a_channel_select,
  output cssr_pkg::cssr_chan_t converter_b_channel_select,
  output logic [1:0] active_entry
);
  import cssr_pkg::*;

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  localparam int POS_W = 2;

  generate
    if (NUM_ENTRIES < 1 || NUM_ENTRIES > 3) begin : g_bad_count
      $error("NUM_ENTRIES must lie between 1 and 3");
    end
  endgenerate

  // ****************************************************************
  // Per-entry constants
  // ****************************************************************
  function automatic logic [`CSSR_IDX_W-1:0] own_index(input int i);
    logic [`CSSR_IDX_W-1:0] idx;
    idx = `CSSR_IDX_ENTRY14;
    case (i)
      1: idx = `CSSR_IDX_ENTRY15;
      2: idx = `CSSR_IDX_ENTRY16;
      default: idx = `CSSR_IDX_ENTRY14;
    endcase
    return idx;
  endfunction : own_index

  function automatic cssr_word_t own_reset(input int i);
    cssr_word_t rv;
    rv = `CSSR_RST_ENTRY14;
    case (i)
      1: rv = `CSSR_RST_ENTRY15;
      2: rv = `CSSR_RST_ENTRY16;
      default: rv = `CSSR_RST_ENTRY14;
    endcase
    return rv;
  endfunction : own_reset

  // ****************************************************************
  // APB decode
  // ****************************************************************
  logic aligned;
  logic [`CSSR_IDX_W-1:0] req_index;
  logic setup_phase;
  logic access_phase;
  logic write_take;
  logic status_hit;
  logic [NUM_ENTRIES-1:0] entry_hit;
  logic [NUM_ENTRIES-1:0] entry_accept;
  logic mapped;

  assign aligned = (paddr[1:0] == 2'h0) && (paddr[11:8] == 4'h0);
  assign req_index = paddr[7:2];
  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  assign write_take = access_phase && pwrite;
  assign status_hit = aligned && (req_index == `CSSR_IDX_STATUS);
  assign mapped = status_hit || (|entry_hit);

  // The slave never inserts wait states.
  assign pready = 1'b1;
  assign pslverr = access_phase && !mapped;

  // ****************************************************************
  // Entry storage
  // ****************************************************************
  cssr_word_t entry_reg [NUM_ENTRIES];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_ENTRIES; gi++) begin : g_entry
      assign entry_hit[gi] = aligned && (req_index == own_index(gi));
      // A write lands only with direction one and the entry's own address.
      assign entry_accept[gi] = write_take && entry_hit[gi]
          && (pwdata[`CSSR_DIR_BIT] == `CSSR_DIR_WRITE)
          && (pwdata[`CSSR_ADDR_MSB:`CSSR_ADDR_LSB] == own_index(gi));

      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          entry_reg[gi] <= own_reset(gi);
        end else if (entry_accept[gi]) begin
          entry_reg[gi][`CSSR_DIR_BIT] <= `CSSR_DIR_READ;
          entry_reg[gi][`CSSR_ADDR_MSB:`CSSR_ADDR_LSB] <= own_index(gi);
          entry_reg[gi][`CSSR_RET_BIT] <= pwdata[`CSSR_RET_BIT];
          entry_reg[gi][`CSSR_CHB_MSB:`CSSR_CHB_LSB] <=
              pwdata[`CSSR_CHB_MSB:`CSSR_CHB_LSB];
          entry_reg[gi][`CSSR_CHA_MSB:`CSSR_CHA_LSB] <=
              pwdata[`CSSR_CHA_MSB:`CSSR_CHA_LSB];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  cssr_state_e state_reg;
  logic [POS_W-1:0] pos_reg;
  logic [POS_W-1:0] pos_next;
  localparam logic [POS_W-1:0] LAST_POS = POS_W'(NUM_ENTRIES - 1);
  cssr_word_t active_word;

  assign active_word = entry_reg[pos_reg];

  always_comb begin
    pos_next = pos_reg;
    if (active_word[`CSSR_RET_BIT] || (pos_reg == LAST_POS)) begin
      pos_next = '0;
    end else begin
      pos_next = pos_reg + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= CSSR_IDLE;
    end else if (!seq_enable) begin
      state_reg <= CSSR_IDLE;
    end else begin
      unique case (state_reg)
        CSSR_IDLE: begin
          if (conv_start) begin
            state_reg <= CSSR_CONVERTING;
          end
        end
        CSSR_CONVERTING: begin
          if (conv_done) begin
            state_reg <= CSSR_IDLE;
          end
        end
      endcase
    end
  end

  // The position moves once the conversion in progress has finished, and clears to zero while seq_enable is low.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pos_reg <= '0;
    end else if (!seq_enable) begin
      pos_reg <= '0;
    end else if (state_reg == CSSR_CONVERTING && conv_done) begin
      pos_reg <= pos_next;
    end
  end

  // Selects are latched at conversion start and held for the conversion.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      converter_a_channel_select <= 4'h0;
      converter_b_channel_select <= 4'h0;
      active_entry <= 2'h0;
    end else if (seq_enable && state_reg == CSSR_IDLE && conv_start) begin
      converter_a_channel_select <= active_word[`CSSR_CHA_MSB:`CSSR_CHA_LSB];
      converter_b_channel_select <= active_word[`CSSR_CHB_MSB:`CSSR_CHB_LSB];
      active_entry <= pos_reg;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  logic [31:0] read_word;

  always_comb begin
    read_word = 32'h0000_0000;
    if (status_hit) begin
      read_word[`CSSR_STAT_POS_MSB:`CSSR_STAT_POS_LSB] = pos_reg;
      read_word[`CSSR_STAT_BUSY_BIT] = (state_reg == CSSR_CONVERTING);
      read_word[`CSSR_STAT_EN_BIT] = seq_enable;
    end
    for (int k = 0; k < NUM_ENTRIES; k++) begin
      if (entry_hit[k]) begin
        read_word[15:0] = entry_reg[k];
      end
    end
  end

  // Read data is captured in the setup cycle and stands through the access.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (setup_phase && !pwrite) begin
      prdata <= read_word;
    end
  end

endmodule : cssr_top
`default_nettype wire

// *** src/cssr_params.svh ***
// Constants of the channel sequence stack entry bank: offsets, fields, resets.
// Assumes inclusion by bare name from the package and the top module.
`ifndef CSSR_PARAMS_SVH
`define CSSR_PARAMS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define CSSR_IDX_ENTRY14 6'h2E
`define CSSR_IDX_ENTRY15 6'h2F
`define CSSR_IDX_ENTRY16 6'h30
`define CSSR_IDX_STATUS 6'h34
`define CSSR_IDX_W 6

// ****************************************************************
// Reset values
// ****************************************************************
`define CSSR_RST_ENTRY14 16'h5C00
`define CSSR_RST_ENTRY15 16'h5E00
`define CSSR_RST_ENTRY16 16'h6000

// ****************************************************************
// Entry word fields
// ****************************************************************
`define CSSR_DIR_BIT 15
`define CSSR_ADDR_MSB 14
`define CSSR_ADDR_LSB 9
`define CSSR_RET_BIT 8
`define CSSR_CHB_MSB 7
`define CSSR_CHB_LSB 4
`define CSSR_CHA_MSB 3
`define CSSR_CHA_LSB 0
`define CSSR_DIR_WRITE 1'h1
`define CSSR_DIR_READ 1'h0

// ****************************************************************
// Status word fields
// ****************************************************************
`define CSSR_STAT_POS_MSB 1
`define CSSR_STAT_POS_LSB 0
`define CSSR_STAT_BUSY_BIT 4
`define CSSR_STAT_EN_BIT 5

`endif

// *** src/cssr_pkg.sv ***
// Types of the channel sequence stack entry bank.
// Assumes the constants header is on the include path.
`include "cssr_params.svh"

package cssr_pkg;

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  typedef enum logic [0:0] {
    CSSR_IDLE = 1'b0,
    CSSR_CONVERTING = 1'b1
  } cssr_state_e;

  typedef logic [15:0] cssr_word_t;
  typedef logic [3:0] cssr_chan_t;

endpackage : cssr_pkg

// *** dv/cssr_top_sva.sv ***
// Checker for the sequence stack entry bank, bound to its top module.
// Assumes entries sit at byte addresses 0xB8 to 0xC0 and 0xC4 is unmapped.
`timescale 1ns/1ps
`default_nettype none
module cssr_top_sva #(
  parameter int NUM_ENTRIES = 3
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic conv_start,
  input wire cssr_pkg::cssr_chan_t converter_a_channel_select,
  input wire cssr_pkg::cssr_chan_t converter_b_channel_select,
  input wire logic [1:0] active_entry
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_ready_one: assert property (pready) else $error("wait inserted");
  chk_err_e15: assert property (psel && penable && paddr == 12'h0BC |-> !pslverr) else $error("e15");
  chk_err_e16: assert property (psel && penable && paddr == 12'h0C0 |-> !pslverr) else $error("e16");
  chk_err_hole: assert property (psel && penable && paddr == 12'h0C4 |-> pslverr) else $error("hole");
  chk_err_setup: assert property (psel && !penable |-> !pslverr) else $error("setup err");
  chk_sel_hold: assert property (!$past(conv_start) |-> $stable(converter_a_channel_select)
    && $stable(converter_b_channel_select)) else $error("select moved");
  chk_pos_hold: assert property (!$past(conv_start) |-> $stable(active_entry)) else $error("pos");
  chk_pos_range: assert property (active_entry < NUM_ENTRIES) else $error("range");
  chk_rst_zero: assert property (!$past(reset_n) |-> active_entry == 2'h0
    && converter_a_channel_select == 4'h0 && converter_b_channel_select == 4'h0) else $error("rst");
endmodule : cssr_top_sva
bind cssr_top cssr_top_sva #(.NUM_ENTRIES(NUM_ENTRIES)) u_sva (.clk(clk), .reset_n(reset_n),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .conv_start(conv_start), .converter_a_channel_select(converter_a_channel_select),
  .converter_b_channel_select(converter_b_channel_select), .active_entry(active_entry));
`default_nettype wire

// *** dv/cssr_conv_model.sv ***
// Converter timing partner: a start pulse, a conversion time, a done pulse.
// Assumes convert is called just after a rising edge of clk.
`timescale 1ns/1ps
`default_nettype none
module cssr_conv_model (
  // Clock.
  input wire logic clk,
  // Conversion timing.
  output logic conv_start,
  output logic conv_done
);
  initial begin
    conv_start = 1'b0;
    conv_done = 1'b0;
  end
  task automatic convert(input int dly);
    conv_start <= 1'b1;
    @(posedge clk);
    conv_start <= 1'b0;
    repeat (dly) @(posedge clk);
    conv_done <= 1'b1;
    @(posedge clk);
    conv_done <= 1'b0;
  endtask : convert
endmodule : cssr_conv_model
`default_nettype wire

// *** dv/channel_sequence_stack_regs_test.sv ***
// Self-checking bench: APB master tasks, entry model, converter partner.
// Assumes zero wait states are not relied on and entries start at index 0x2E.
`timescale 1ns/1ps
`default_nettype none
module channel_sequence_stack_regs_test;
  logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, seq_enable = 1'b0, conv_start, conv_done, e;
  cssr_pkg::cssr_chan_t sel_a, sel_b;
  logic [1:0] act;
  int n_mismatch = 0, tests_run = 0, seed = 417, ent[3], pos, k, i;
  logic [8:0] low;
  logic wr;
  always #5 clk = ~clk;
  cssr_top uut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .seq_enable(seq_enable), .conv_start(conv_start), .conv_done(conv_done),
    .converter_a_channel_select(sel_a), .converter_b_channel_select(sel_b), .active_entry(act));
  cssr_conv_model cm (.clk(clk), .conv_start(conv_start), .conv_done(conv_done));
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, s, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  initial begin
    #50000;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    ent = '{32'h5C00, 32'h5E00, 32'h6000};
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    for (k = 0; k < 3; k++) begin
      apb(1'b0, 12'h0B8 + 12'(4 * k), 32'h0);
      chk(r, ent[k]);
    end
    apb(1'b0, 12'h0C4, 32'h0);
    chk({r[30:0], e}, 32'h1);
    apb(1'b0, 12'h0D0, 32'h0);
    chk({r[30:0], e}, 32'h0);
    apb(1'b1, 12'h0B8, {16'h0, 1'b1, 6'h31, 9'h1FF});
    apb(1'b0, 12'h0B8, 32'h0);
    chk(r, ent[0]);
    for (i = 0; i < 12; i++) begin
      k = {$random(seed)} % 3;
      low = 9'($random(seed));
      wr = 1'($random(seed));
      apb(1'b1, 12'h0B8 + 12'(4 * k), {16'h0, wr, 6'(8'h2E + k), low});
      if (wr) ent[k] = ((8'h2E + k) << 9) | low;
      apb(1'b0, 12'h0B8 + 12'(4 * k), 32'h0);
      chk(r, ent[k]);
    end
    @(posedge clk);
    cm.convert(1);
    chk({sel_b, sel_a, act}, 10'h0);
    seq_enable <= 1'b1;
    pos = 0;
    for (i = 0; i < 9; i++) begin
      @(posedge clk);
      cm.convert(i % 3);
      chk(act, pos);
      chk(sel_a, ent[pos] & 15);
      chk(sel_b, (ent[pos] >> 4) & 15);
      pos = (ent[pos][8] || pos == 2) ? 0 : pos + 1;
    end
    apb(1'b0, 12'h0D0, 32'h0);
    chk(r, 32'h20 | pos);
    report_and_stop();
  end
endmodule : channel_sequence_stack_regs_test
`default_nettype wire
